// ===== design/pts_pkg.sv
// Shared constants and types for the programmable timer and serial link.
// Assumes one system clock; the serial link clock arrives as its own port.
package pts_pkg;
	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int PTS_CNT_W = 8;
	localparam int PTS_NIB_W = 4;
	localparam int PTS_SD_W = 8;
	localparam int PTS_BITCNT_W = 3;
	localparam int PTS_PRE_W = 16;
	// ----------------------------------------
	// Reset and fixed values
	// ----------------------------------------
	localparam logic [PTS_CNT_W-1:0] PTS_CNT_RST = 8'h00;
	localparam logic [PTS_CNT_W-1:0] PTS_CNT_FULL = 8'hff;
	localparam logic [PTS_SD_W-1:0] PTS_SD_RST = 8'h00;
	localparam logic [PTS_BITCNT_W-1:0] PTS_BIT_FIRST = 3'h1;
	localparam logic [PTS_BITCNT_W-1:0] PTS_BIT_LAST = 3'h7;
	// Input clock dividers, in system clocks per counter clock
	localparam logic [PTS_PRE_W-1:0] PTS_PRE_SLOW = 16'h1800;
	localparam logic [PTS_PRE_W-1:0] PTS_PRE_FAST = 16'h0032;
	// ----------------------------------------
	// Nibble read selects and flag positions
	// ----------------------------------------
	localparam logic [1:0] PTS_NIB_C0L = 2'h0;
	localparam logic [1:0] PTS_NIB_C0H = 2'h1;
	localparam logic [1:0] PTS_NIB_C1L = 2'h2;
	localparam logic [1:0] PTS_NIB_C1H = 2'h3;
	localparam int PTS_FLG_C0 = 0;
	localparam int PTS_FLG_C1 = 1;
	localparam int PTS_FLG_SER = 2;
	localparam int PTS_FLG_W = 3;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef struct packed {
		logic running;
		logic [PTS_CNT_W-1:0] value;
	} pts_chan_t;
	typedef enum logic [1:0] {
		PTS_SER_IDLE = 2'b01,
		PTS_SER_BUSY = 2'b10
	} pts_ser_state_t;
endpackage

// ===== design/pts_timer_serial.sv
// Two 8-bit down counters, joinable to 16 bits, plus a clocked serial port.
// Assumes SCLK comes from the far device, idles high and stops between
// frames; RST is held while SCLK runs at least once so the link side resets.
`timescale 1ns/100ps
module pts_timer_serial #(
	parameter logic [pts_pkg::PTS_PRE_W-1:0] PRE_SLOW = pts_pkg::PTS_PRE_SLOW,
	parameter logic [pts_pkg::PTS_PRE_W-1:0] PRE_FAST = pts_pkg::PTS_PRE_FAST
) (
	input wire logic SYS_CLK,
	input wire logic RST,
	input wire logic SCLK,
	input wire logic EVENT_CLOCK_PIN,
	input wire logic JOINED_WIDTH_SELECT,
	input wire logic CNT0_EVENT_MODE,
	input wire logic FAST_CLK_SEL,
	input wire logic FAST_OSC_ON_REQ,
	output logic FAST_OSCILLATOR_ON,
	input wire logic CNT0_RUN_CTL,
	input wire logic CNT1_RUN_CTL,
	output logic CNT0_RUN_STAT,
	output logic CNT1_RUN_STAT,
	input wire logic [pts_pkg::PTS_CNT_W-1:0] CNT0_RELOAD,
	input wire logic [pts_pkg::PTS_CNT_W-1:0] CNT1_RELOAD,
	input wire logic NIB_RD_STB,
	input wire logic [1:0] NIB_RD_SEL,
	output logic [pts_pkg::PTS_NIB_W-1:0] NIB_RD_DATA,
	input wire logic TIMER_OUT_ENABLE,
	output logic TIMER_OUT_SIGNAL,
	input wire logic [pts_pkg::PTS_FLG_W-1:0] IRQ_MASK,
	input wire logic [pts_pkg::PTS_FLG_W-1:0] FLAG_CLR,
	output logic [pts_pkg::PTS_FLG_W-1:0] IRQ_FLAGS,
	output logic IRQ_REQ,
	input wire logic SERIAL_ENABLE_CTL,
	input wire logic BIT_ORDER_SELECT,
	input wire logic SD_WR_STB,
	input wire logic SD_RD_STB,
	input wire logic [pts_pkg::PTS_SD_W-1:0] SD_WDATA,
	output logic [pts_pkg::PTS_SD_W-1:0] SD_RDATA,
	input wire logic SERIAL_TRIGGER,
	output logic SERIAL_BUSY,
	input wire logic SDI,
	output logic SDO
);
	import pts_pkg::*;

	function automatic logic [PTS_SD_W-1:0] order(
		input logic [PTS_SD_W-1:0] d,
		input logic lsb_first
	);
		logic [PTS_SD_W-1:0] r;
		r = d;
		for (int i = 0; i < PTS_SD_W; i++) begin
			if (lsb_first) begin
				r[i] = d[PTS_SD_W-1-i];
			end
		end
		return r;
	endfunction

	// ----------------------------------------
	// Input clock selection
	// ----------------------------------------
	// Pin goes through two flops before the edge detector looks at it
	logic ev_s1_ff, ev_s2_ff, ev_s3_ff;
	logic [PTS_PRE_W-1:0] pre_ff, nxt_pre;
	logic osc_ff, nxt_osc;
	logic ptick, evfall;

	always_comb begin
		nxt_osc = FAST_OSC_ON_REQ;
		ptick = 1'b0;
		nxt_pre = pre_ff + 16'h0001;
		// Fast source is dead until the oscillator runs
		if (FAST_CLK_SEL && !osc_ff) begin
			nxt_pre = pre_ff;
		end else if (pre_ff >= (FAST_CLK_SEL ? PRE_FAST : PRE_SLOW) - 16'h0001) begin
			nxt_pre = '0;
			ptick = 1'b1;
		end
		evfall = ev_s3_ff & ~ev_s2_ff;
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			osc_ff <= 1'b0;
			pre_ff <= '0;
			ev_s1_ff <= 1'b0;
			ev_s2_ff <= 1'b0;
			ev_s3_ff <= 1'b0;
		end else begin
			osc_ff <= nxt_osc;
			pre_ff <= nxt_pre;
			ev_s1_ff <= EVENT_CLOCK_PIN;
			ev_s2_ff <= ev_s1_ff;
			ev_s3_ff <= ev_s2_ff;
		end
	end

	// ----------------------------------------
	// Counters
	// ----------------------------------------
	pts_chan_t c0_ff, c1_ff, nxt_c0, nxt_c1;
	logic uf0, uf1, tick0;

	always_comb begin
		nxt_c0 = c0_ff;
		nxt_c1 = c1_ff;
		uf0 = 1'b0;
		uf1 = 1'b0;
		tick0 = CNT0_EVENT_MODE ? evfall : ptick;
		if (tick0) begin
			nxt_c0.running = CNT0_RUN_CTL;
			if (c0_ff.running) begin
				if (c0_ff.value != PTS_CNT_RST) begin
					nxt_c0.value = c0_ff.value - 8'h01;
				end else if (!JOINED_WIDTH_SELECT) begin
					nxt_c0.value = CNT0_RELOAD;
					uf0 = 1'b1;
				end else if (c1_ff.value == PTS_CNT_RST) begin
					nxt_c0.value = CNT0_RELOAD;
					nxt_c1.value = CNT1_RELOAD;
					uf1 = 1'b1;
				end else begin
					nxt_c0.value = PTS_CNT_FULL;
					nxt_c1.value = c1_ff.value - 8'h01;
				end
			end
		end
		if (!JOINED_WIDTH_SELECT && ptick) begin
			nxt_c1.running = CNT1_RUN_CTL;
			if (c1_ff.running) begin
				if (c1_ff.value != PTS_CNT_RST) begin
					nxt_c1.value = c1_ff.value - 8'h01;
				end else begin
					nxt_c1.value = CNT1_RELOAD;
					uf1 = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			c0_ff <= '{running: 1'b0, value: PTS_CNT_RST};
			c1_ff <= '{running: 1'b0, value: PTS_CNT_RST};
		end else begin
			c0_ff <= nxt_c0;
			c1_ff <= nxt_c1;
		end
	end

	// ----------------------------------------
	// Nibble reads and timer output
	// ----------------------------------------
	// Upper nibbles are frozen on a low read so a carry between reads
	// cannot tear the value
	logic [11:0] snap_ff, nxt_snap;
	logic [PTS_NIB_W-1:0] nib_ff, nxt_nib;
	logic tog_ff, nxt_tog, timer_out_signal_ff, nxt_timer_out_signal;

	always_comb begin
		nxt_snap = snap_ff;
		nxt_nib = nib_ff;
		if (NIB_RD_STB) begin
			case (NIB_RD_SEL)
				PTS_NIB_C0L: begin
					nxt_nib = c0_ff.value[3:0];
					nxt_snap = {c1_ff.value, c0_ff.value[7:4]};
				end
				PTS_NIB_C0H: nxt_nib = snap_ff[3:0];
				PTS_NIB_C1L: begin
					if (JOINED_WIDTH_SELECT) begin
						nxt_nib = snap_ff[7:4];
					end else begin
						nxt_nib = c1_ff.value[3:0];
						nxt_snap[11:8] = c1_ff.value[7:4];
					end
				end
				PTS_NIB_C1H: nxt_nib = snap_ff[11:8];
				default: nxt_nib = nib_ff;
			endcase
		end
		nxt_tog = tog_ff ^ (JOINED_WIDTH_SELECT ? uf1 : uf0);
		// enable gates without resync, may clip a half cycle
		nxt_timer_out_signal = tog_ff & TIMER_OUT_ENABLE;
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			snap_ff <= '0;
			nib_ff <= '0;
			tog_ff <= 1'b0;
			timer_out_signal_ff <= 1'b0;
		end else begin
			snap_ff <= nxt_snap;
			nib_ff <= nxt_nib;
			tog_ff <= nxt_tog;
			timer_out_signal_ff <= nxt_timer_out_signal;
		end
	end

	// ----------------------------------------
	// Serial control, system side
	// ----------------------------------------
	pts_ser_state_t ser_ff, nxt_ser;
	logic [PTS_SD_W-1:0] tx_ff, nxt_tx, rx_ff, nxt_rx;
	logic armed_ff, nxt_armed, start_tog_ff, nxt_start_tog;
	logic dn_s1_ff, dn_s2_ff, dn_s3_ff;
	logic [PTS_FLG_W-1:0] flg_ff, nxt_flg;
	logic irq_ff, nxt_irq;
	logic [PTS_SD_W-1:0] lk_sr_ff;
	logic lk_done_tog_ff;
	logic done_ev;

	always_comb begin
		nxt_ser = ser_ff;
		nxt_tx = tx_ff;
		nxt_rx = rx_ff;
		nxt_armed = armed_ff;
		nxt_start_tog = start_tog_ff;
		done_ev = dn_s3_ff ^ dn_s2_ff;
		if (SD_WR_STB) begin
			nxt_tx = order(SD_WDATA, BIT_ORDER_SELECT);
			nxt_armed = 1'b1;
		end else if (SD_RD_STB) begin
			nxt_armed = 1'b1;
		end
		case (ser_ff)
			PTS_SER_IDLE: begin
				if (SERIAL_TRIGGER && SERIAL_ENABLE_CTL && armed_ff) begin
					nxt_start_tog = ~start_tog_ff;
					nxt_armed = 1'b0;
					nxt_ser = PTS_SER_BUSY;
				end
			end
			PTS_SER_BUSY: begin
				// Link word is still while the link clock has stopped
				if (done_ev) begin
					nxt_rx = order(lk_sr_ff, BIT_ORDER_SELECT);
					nxt_ser = PTS_SER_IDLE;
				end
			end
			default: nxt_ser = PTS_SER_IDLE;
		endcase
		// set regardless of mask; set beats clear
		nxt_flg = flg_ff & ~FLAG_CLR;
		// counter flags bits one and zero
		nxt_flg[PTS_FLG_C0] = nxt_flg[PTS_FLG_C0] | uf0;
		nxt_flg[PTS_FLG_C1] = nxt_flg[PTS_FLG_C1] | uf1;
		nxt_flg[PTS_FLG_SER] = nxt_flg[PTS_FLG_SER] |
			(done_ev && ser_ff == PTS_SER_BUSY);
		nxt_irq = |(flg_ff & IRQ_MASK);
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			ser_ff <= PTS_SER_IDLE;
			tx_ff <= PTS_SD_RST;
			rx_ff <= PTS_SD_RST;
			armed_ff <= 1'b0;
			start_tog_ff <= 1'b0;
			dn_s1_ff <= 1'b0;
			dn_s2_ff <= 1'b0;
			dn_s3_ff <= 1'b0;
			flg_ff <= '0;
			irq_ff <= 1'b0;
		end else begin
			ser_ff <= nxt_ser;
			tx_ff <= nxt_tx;
			rx_ff <= nxt_rx;
			armed_ff <= nxt_armed;
			start_tog_ff <= nxt_start_tog;
			dn_s1_ff <= lk_done_tog_ff;
			dn_s2_ff <= dn_s1_ff;
			dn_s3_ff <= dn_s2_ff;
			flg_ff <= nxt_flg;
			irq_ff <= nxt_irq;
		end
	end

	// ----------------------------------------
	// Serial link, SCLK side
	// ----------------------------------------
	// Start toggle and transmit word are held static from the trigger until
	// done, and the far end clocks only after the trigger, so no
	// synchroniser is needed and no SCLK edges are lost.
	logic [PTS_SD_W-1:0] nxt_lk_sr;
	logic [PTS_BITCNT_W-1:0] lk_cnt_ff, nxt_lk_cnt;
	logic lk_take_ff, nxt_lk_take, nxt_lk_done_tog;
	logic lk_sdo_ff, nxt_lk_sdo;

	always_comb begin
		nxt_lk_sr = lk_sr_ff;
		nxt_lk_cnt = lk_cnt_ff;
		nxt_lk_take = lk_take_ff;
		nxt_lk_done_tog = lk_done_tog_ff;
		// frame opens on first edge after trigger
		if (start_tog_ff != lk_take_ff) begin
			nxt_lk_sr = {tx_ff[PTS_SD_W-2:0], SDI};
			nxt_lk_cnt = PTS_BIT_FIRST;
			nxt_lk_take = start_tog_ff;
		end else if (lk_cnt_ff != '0) begin
			nxt_lk_sr = {lk_sr_ff[PTS_SD_W-2:0], SDI};
			nxt_lk_cnt = lk_cnt_ff + PTS_BIT_FIRST;
			if (lk_cnt_ff == PTS_BIT_LAST) begin
				nxt_lk_done_tog = ~lk_done_tog_ff;
			end
		end
		nxt_lk_sdo = (start_tog_ff != lk_take_ff) ? tx_ff[PTS_SD_W-1] :
			lk_sr_ff[PTS_SD_W-1];
	end

	always_ff @(posedge SCLK) begin
		if (RST) begin
			lk_sr_ff <= PTS_SD_RST;
			lk_cnt_ff <= '0;
			lk_take_ff <= 1'b0;
			lk_done_tog_ff <= 1'b0;
		end else begin
			lk_sr_ff <= nxt_lk_sr;
			lk_cnt_ff <= nxt_lk_cnt;
			lk_take_ff <= nxt_lk_take;
			lk_done_tog_ff <= nxt_lk_done_tog;
		end
	end

	// Data leaves on the falling edge so the far end samples on the rise
	always_ff @(negedge SCLK) begin
		if (RST) begin
			lk_sdo_ff <= 1'b0;
		end else begin
			lk_sdo_ff <= nxt_lk_sdo;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// status shows the true running state
	assign CNT0_RUN_STAT = c0_ff.running;
	assign CNT1_RUN_STAT = c1_ff.running;
	assign FAST_OSCILLATOR_ON = osc_ff;
	assign NIB_RD_DATA = nib_ff;
	assign TIMER_OUT_SIGNAL = timer_out_signal_ff;
	assign IRQ_FLAGS = flg_ff;
	assign IRQ_REQ = irq_ff;
	assign SD_RDATA = rx_ff;
	assign SERIAL_BUSY = (ser_ff == PTS_SER_BUSY);
	assign SDO = lk_sdo_ff;
endmodule

// ===== bench/pts_sva.sv
// Checker for the timer and serial link, bound to its top module.
// Assumes one system clock; the link side is judged by the bench.
`timescale 1ns/100ps
module pts_sva #(
	parameter logic [pts_pkg::PTS_PRE_W-1:0] PRE_SLOW = pts_pkg::PTS_PRE_SLOW
) (
	input wire logic SYS_CLK,
	input wire logic RST,
	input wire logic CNT0_EVENT_MODE,
	input wire logic FAST_CLK_SEL,
	input wire logic CNT0_RUN_CTL,
	input wire logic CNT0_RUN_STAT,
	input wire logic NIB_RD_STB,
	input wire logic [pts_pkg::PTS_NIB_W-1:0] NIB_RD_DATA,
	input wire logic TIMER_OUT_ENABLE,
	input wire logic TIMER_OUT_SIGNAL,
	input wire logic [pts_pkg::PTS_FLG_W-1:0] IRQ_MASK,
	input wire logic [pts_pkg::PTS_FLG_W-1:0] FLAG_CLR,
	input wire logic [pts_pkg::PTS_FLG_W-1:0] IRQ_FLAGS,
	input wire logic IRQ_REQ,
	input wire logic SERIAL_ENABLE_CTL,
	input wire logic SD_WR_STB,
	input wire logic SD_RD_STB,
	input wire logic SERIAL_TRIGGER,
	input wire logic SERIAL_BUSY
);
	import pts_pkg::*;
	// Slack of two clocks covers the tick register and the stop edge
	localparam int STOP_LIM = PRE_SLOW + 2;
	logic arm_ff;
	logic nxt_arm;
	// ----------------------------
	// Arming as the checker sees it
	// ----------------------------
	always_comb begin
		nxt_arm = arm_ff;
		if (SD_WR_STB || SD_RD_STB) begin
			nxt_arm = 1'b1;
		end else if (SERIAL_TRIGGER && SERIAL_ENABLE_CTL && !SERIAL_BUSY) begin
			nxt_arm = 1'b0;
		end
	end
	always_ff @(posedge SYS_CLK) begin
		arm_ff <= RST ? 1'b0 : nxt_arm;
	end
	default clocking @(posedge SYS_CLK);
	endclocking
	default disable iff (RST);
	sequence s_trig_ok;
		SERIAL_TRIGGER && SERIAL_ENABLE_CTL && arm_ff && !SERIAL_BUSY;
	endsequence
	sequence s_trig_bad;
		SERIAL_TRIGGER && !SERIAL_BUSY && !(SERIAL_ENABLE_CTL && arm_ff);
	endsequence
	property p_flag_hold;
		(IRQ_FLAGS & ~FLAG_CLR) != 3'h0 |=>
			(IRQ_FLAGS & $past(IRQ_FLAGS) & ~$past(FLAG_CLR)) ==
			($past(IRQ_FLAGS) & ~$past(FLAG_CLR));
	endproperty
	a_flag_hold: assert property (p_flag_hold)
		else $error("flag dropped without clear");
	property p_irq_req;
		IRQ_REQ == |($past(IRQ_FLAGS) & $past(IRQ_MASK));
	endproperty
	a_irq_req: assert property (p_irq_req)
		else $error("request not flags and mask");
	property p_run_rose;
		$rose(CNT0_RUN_STAT) |-> $past(CNT0_RUN_CTL);
	endproperty
	a_run_rose: assert property (p_run_rose)
		else $error("started without run request");
	property p_run_fell;
		$fell(CNT0_RUN_STAT) |-> !$past(CNT0_RUN_CTL);
	endproperty
	a_run_fell: assert property (p_run_fell)
		else $error("stopped while run requested");
	property p_stop_lim;
		!CNT0_RUN_CTL && !CNT0_EVENT_MODE && !FAST_CLK_SEL |->
			##[0:STOP_LIM] !CNT0_RUN_STAT;
	endproperty
	a_stop_lim: assert property (p_stop_lim)
		else $error("stop not taken at tick");
	property p_timer_out_signal;
		!TIMER_OUT_ENABLE |=> !TIMER_OUT_SIGNAL;
	endproperty
	a_timer_out_signal: assert property (p_timer_out_signal)
		else $error("output not gated");
	property p_nib;
		!NIB_RD_STB |=> $stable(NIB_RD_DATA);
	endproperty
	a_nib: assert property (p_nib)
		else $error("nibble changed without read");
	property p_trig_ok;
		s_trig_ok |=> SERIAL_BUSY;
	endproperty
	a_trig_ok: assert property (p_trig_ok)
		else $error("trigger not taken");
	property p_trig_bad;
		s_trig_bad |=> !SERIAL_BUSY;
	endproperty
	a_trig_bad: assert property (p_trig_bad)
		else $error("trigger taken unarmed or disabled");
	property p_ser_flag;
		$fell(SERIAL_BUSY) |-> ##[0:1] IRQ_FLAGS[PTS_FLG_SER];
	endproperty
	a_ser_flag: assert property (p_ser_flag)
		else $error("serial flag not set");
endmodule
bind pts_timer_serial pts_sva #(.PRE_SLOW(PRE_SLOW)) sva_u (
	.SYS_CLK(SYS_CLK), .RST(RST), .CNT0_EVENT_MODE(CNT0_EVENT_MODE),
	.FAST_CLK_SEL(FAST_CLK_SEL), .CNT0_RUN_CTL(CNT0_RUN_CTL),
	.CNT0_RUN_STAT(CNT0_RUN_STAT), .NIB_RD_STB(NIB_RD_STB),
	.NIB_RD_DATA(NIB_RD_DATA), .TIMER_OUT_ENABLE(TIMER_OUT_ENABLE),
	.TIMER_OUT_SIGNAL(TIMER_OUT_SIGNAL), .IRQ_MASK(IRQ_MASK),
	.FLAG_CLR(FLAG_CLR), .IRQ_FLAGS(IRQ_FLAGS), .IRQ_REQ(IRQ_REQ),
	.SERIAL_ENABLE_CTL(SERIAL_ENABLE_CTL), .SD_WR_STB(SD_WR_STB),
	.SD_RD_STB(SD_RD_STB), .SERIAL_TRIGGER(SERIAL_TRIGGER),
	.SERIAL_BUSY(SERIAL_BUSY)
);

// ===== bench/pts_far_dev.sv
// Far serial device: makes the link clock, sends a byte, captures ours.
// Assumes the bench starts a frame only after the trigger is taken.
`timescale 1ns/100ps
module pts_far_dev (
	output logic sclk,
	output logic sdi,
	input wire logic sdo,
	input wire logic go,
	input wire logic slow,
	input wire logic [7:0] tx,
	output logic [7:0] rx,
	output logic done
);
	// One pulse inside reset so the link flops are cleared
	initial begin
		sclk = 1'b1;
		sdi = 1'b1;
		rx = 8'h00;
		done = 1'b0;
		#5 sclk = 1'b0;
		#3 sclk = 1'b1;
	end
	always @(posedge go) begin
		done = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			// slow spacing keeps the link clock down
			if (slow)
				#9;
			#3 sclk = 1'b0;
			sdi = tx[i];
			#3 sclk = 1'b1;
			rx = {rx[6:0], sdo};
		end
		// Released line shows the inverse, never a stale bit
		#3 sdi = ~tx[0];
		done = 1'b1;
	end
endmodule

// ===== bench/test_prog_timer_serial_link.sv
// Self-checking bench for the timer and serial link.
// Assumes the far device model and the bound checker.
`timescale 1ns/100ps
module test_prog_timer_serial_link;
	import pts_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic sclk, sdi, sdo, pin, jn, evm, osc_req, osc_on, run0, st0, stb;
	logic timer_out_signal_en, timer_out_signal, irq, ser_en, ord, sd_wr, trig, busy, go, slow, done;
	logic run1, st1;
	logic [7:0] rl0, rl1, wd, rd, tx, rx;
	logic [1:0] sel;
	logic [3:0] nib;
	logic [2:0] msk, clr, flg;
	int err_count = 0;
	int cmp_count = 0;
	always #2.5 clk = ~clk;
	pts_timer_serial #(.PRE_SLOW(16'h0004), .PRE_FAST(16'h0002)) dut_u (
		.SYS_CLK(clk), .RST(rst), .SCLK(sclk), .EVENT_CLOCK_PIN(pin),
		.JOINED_WIDTH_SELECT(jn), .CNT0_EVENT_MODE(evm), .FAST_CLK_SEL(1'b0),
		.FAST_OSC_ON_REQ(osc_req), .FAST_OSCILLATOR_ON(osc_on),
		.CNT0_RUN_CTL(run0), .CNT1_RUN_CTL(run1), .CNT0_RUN_STAT(st0),
		.CNT1_RUN_STAT(st1), .CNT0_RELOAD(rl0), .CNT1_RELOAD(rl1),
		.NIB_RD_STB(stb), .NIB_RD_SEL(sel), .NIB_RD_DATA(nib),
		.TIMER_OUT_ENABLE(timer_out_signal_en), .TIMER_OUT_SIGNAL(timer_out_signal), .IRQ_MASK(msk),
		.FLAG_CLR(clr), .IRQ_FLAGS(flg), .IRQ_REQ(irq),
		.SERIAL_ENABLE_CTL(ser_en), .BIT_ORDER_SELECT(ord),
		.SD_WR_STB(sd_wr), .SD_RD_STB(1'b0), .SD_WDATA(wd), .SD_RDATA(rd),
		.SERIAL_TRIGGER(trig), .SERIAL_BUSY(busy), .SDI(sdi), .SDO(sdo)
	);
	pts_far_dev far_u (.sclk(sclk), .sdi(sdi), .sdo(sdo), .go(go),
		.slow(slow), .tx(tx), .rx(rx), .done(done));
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		cmp_count++;
		if (s !== e) begin
			err_count++;
			$display("wrong value %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	// pin only clocks the counter; no port interrupt is modelled
	task automatic pulse();
		pin = 1'b0;
		cyc(5);
		pin = 1'b1;
		cyc(5);
	endtask
	// Low nibble first, then high
	task automatic rd_cnt(input int c, input logic [7:0] e);
		logic [7:0] v;
		for (int h = 0; h < 2; h++) begin
			sel = 2'(2 * c + h);
			stb = 1'b1;
			cyc(1);
			stb = 1'b0;
			v[4*h +: 4] = nib;
			cyc(1);
		end
		chk("count", v, e);
	endtask
	task automatic strobe(input logic wr);
		sd_wr = wr;
		trig = !wr;
		cyc(1);
		{sd_wr, trig} = 2'b00;
		cyc(2);
	endtask
	task automatic flag_clr(input logic [2:0] m);
		clr = m;
		cyc(1);
		clr = 3'h0;
		cyc(2);
		chk("flags", 8'(flg), 8'h00);
	endtask
	function automatic logic [7:0] rev(input logic [7:0] x);
		for (int i = 0; i < 8; i++)
			rev[i] = x[7 - i];
	endfunction
	task automatic test_done();
		$display("checks %0d errors %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		#20000;
		err_count++;
		test_done();
	end
	initial begin
		{jn, evm, run0, stb, timer_out_signal_en, ser_en, ord, sd_wr, trig} = '0;
		{go, slow, osc_req, pin} = 4'h1;
		run1 = 1'b0;
		{rl0, rl1, wd, tx, sel, msk, clr} = '0;
		cyc(6);
		rst = 1'b0;
		cyc(2);
		chk("osc", 8'(osc_on), 8'h00);
		{evm, run0, rl0} = {2'b11, 8'h42};
		cyc(10);
		chk("run", 8'(st0), 8'h00);
		pulse();
		chk("run", 8'(st0), 8'h01);
		pulse();
		chk("flags", 8'(flg), 8'h01);
		chk("req", 8'(irq), 8'h00);
		pulse();
		rd_cnt(0, 8'h41);
		timer_out_signal_en = 1'b1;
		cyc(2);
		chk("timer_out_signal", 8'(timer_out_signal), 8'h01);
		timer_out_signal_en = 1'b0;
		msk = 3'h1;
		cyc(3);
		chk("timer_out_signal", 8'(timer_out_signal), 8'h00);
		chk("req", 8'(irq), 8'h01);
		flag_clr(3'h1);
		run0 = 1'b0;
		cyc(10);
		chk("run", 8'(st0), 8'h01);
		pulse();
		chk("run", 8'(st0), 8'h00);
		rd_cnt(0, 8'h40);
		pulse();
		rd_cnt(0, 8'h40);
		{rst, msk, jn, rl0, rl1, run0} = {1'b1, 3'h0, 1'b1, 16'h0001, 1'b1};
		cyc(6);
		rst = 1'b0;
		cyc(2);
		pulse();
		pulse();
		chk("flags", 8'(flg), 8'h02);
		pulse();
		rd_cnt(0, 8'hff);
		rd_cnt(1, 8'h00);
		flag_clr(3'h2);
		ser_en = 1'b1;
		strobe(1'b0);
		chk("busy", 8'(busy), 8'h00);
		ser_en = 1'b0;
		strobe(1'b1);
		strobe(1'b0);
		chk("busy", 8'(busy), 8'h00);
		for (int o = 0; o < 2; o++) begin
			{ord, slow, ser_en, wd, tx} = {o[0], o[0], 1'b1, 16'hb41c};
			cyc(1);
			// data touched only while the link is idle
			strobe(1'b1);
			strobe(1'b0);
			chk("busy", 8'(busy), 8'h01);
			go = 1'b1;
			// Let the far model clear its done flag first
			cyc(1);
			for (int i = 0; i < 60 && !done; i++)
				cyc(1);
			go = 1'b0;
			for (int i = 0; i < 20 && busy; i++)
				cyc(1);
			chk("tx", rx, o ? rev(8'hb4) : 8'hb4);
			chk("rx", rd, o ? rev(8'h1c) : 8'h1c);
			chk("flags", 8'(flg), 8'h04);
			flag_clr(3'h4);
		end
		{jn, evm, run1} = 3'b001;
		cyc(8);
		chk("run", 8'(st0), 8'h01);
		chk("run1", 8'(st1), 8'h01);
		run0 = 1'b0;
		cyc(8);
		chk("run", 8'(st0), 8'h00);
		chk("run1", 8'(st1), 8'h01);
		// software turns the fast oscillator on before use
		osc_req = 1'b1;
		cyc(2);
		chk("osc", 8'(osc_on), 8'h01);
		test_done();
	end
endmodule
